// ### verilog/alsi_cfg.svh
// constants for the axis limit and slow-down input block
// assumes a 40 MHz pclk and a byte-addressed apb bus
`ifndef ALSI_CFG_SVH
`define ALSI_CFG_SVH
// register byte offsets
`define ALSI_OFS_ENV1      8'h00
`define ALSI_OFS_ERR       8'h04
`define ALSI_OFS_MODE      8'h08
`define ALSI_OFS_SSTS      8'h0C
`define ALSI_OFS_XSTS      8'h10
// first environment register fields
`define ALSI_ENV1_ELM      3
`define ALSI_ENV1_SDM      4
`define ALSI_ENV1_SDLT     5
`define ALSI_ENV1_SDL      6
`define ALSI_ENV1_FTM_LO   20
`define ALSI_ENV1_FTM_HI   21
`define ALSI_ENV1_FLTR     26
// operation mode register fields
`define ALSI_MODE_MSDE     8
// error cause register fields
`define ALSI_ERR_PL        0
`define ALSI_ERR_ML        1
`define ALSI_ERR_SD        5
// status fields
`define ALSI_SSTS_PL       12
`define ALSI_SSTS_ML       13
`define ALSI_SSTS_LATCH    15
`define ALSI_XSTS_SD       14
// reset values
`define ALSI_RST_WORD      32'h0000_0000
// timing
`define ALSI_CLK_NS        25
`define ALSI_FT0_NS        3200
`define ALSI_FT1_NS        1600
`define ALSI_FT2_NS        800
`define ALSI_FT3_NS        400
`define ALSI_NOFLT_CYC     8'h02
// filter widths in cycles, least times rounded up to whole cycles
`define ALSI_FT0_CYC ((`ALSI_FT0_NS + `ALSI_CLK_NS - 1) / `ALSI_CLK_NS)
`define ALSI_FT1_CYC ((`ALSI_FT1_NS + `ALSI_CLK_NS - 1) / `ALSI_CLK_NS)
`define ALSI_FT2_CYC ((`ALSI_FT2_NS + `ALSI_CLK_NS - 1) / `ALSI_CLK_NS)
`define ALSI_FT3_CYC ((`ALSI_FT3_NS + `ALSI_CLK_NS - 1) / `ALSI_CLK_NS)
`endif

// ### verilog/alsi_pkg.sv
// types shared by the axis limit and slow-down input block
// assumes alsi_cfg.svh for all numeric constants
package alsi_pkg;
    // axis motion state, one-hot
    typedef enum logic [2:0] {
        ALSI_IDLE  = 3'b001,
        ALSI_RUN   = 3'b010,
        ALSI_DSTOP = 3'b100
    } alsi_state_t;
    // speed pattern given with a start
    typedef enum logic [1:0] {
        ALSI_PAT_LOW   = 2'h0,
        ALSI_PAT_HIGH  = 2'h1,
        ALSI_PAT_ACCEL = 2'h2
    } alsi_pat_t;
    // filter state
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       lvl;
        logic [7:0] cnt;
    } alsi_flt_t;
    // top state; cause and err bits are {slowdown, negative, positive}
    typedef struct packed {
        logic [31:0] env;
        logic [31:0] mode;
        logic [2:0]  err;
        logic        pol1;
        logic        pol2;
        logic        latch;
        alsi_state_t st;
        alsi_pat_t   pat;
        logic [2:0]  cause;
        logic        dir;
        logic        running;
        logic        hs;
        logic        dstop;
        logic        imm_stop;
        logic        refused;
        logic        no_motion;
        logic        err_evt;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } alsi_regs_t;
endpackage

// ### verilog/alsi_filter.sv
// two-stage synchroniser followed by a pulse-width noise filter
// assumes width_cyc is steady from pclk and at least one
`timescale 1ns/1ps
module alsi_filter
    import alsi_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       pin_in,
    input  wire logic [7:0] width_cyc,
    output logic            level
);
    alsi_flt_t r;       // registered state
    alsi_flt_t next_r;  // next state

    // synchronise, then accept a new level only after width_cyc cycles
    always_comb begin
        next_r = r;
        next_r.s1 = pin_in;
        next_r.s2 = r.s1;
        if (r.s2 == r.lvl) begin
            next_r.cnt = 8'h00;
        end else if (r.cnt + 8'h01 >= width_cyc) begin
            next_r.lvl = r.s2;
            next_r.cnt = 8'h00;
        end else begin
            next_r.cnt = r.cnt + 8'h01;
        end
    end

    // register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign level = r.lvl;
endmodule

// ### verilog/alsi_axis.sv
// axis end-limit and slow-down input handling with apb registers
// assumes motion controls on pclk; switch pins asynchronous
//
// Functional notes
// - limit in moving direction forces abnormal stop
// - env bit 3 picks immediate or decel stop
// - no start toward an active limit
// - polarity pin low means active-high limits
// - filter bit 26 enforces minimum width
// - unfiltered slow-down needs two cycles
// - sub-status bits 12,13 show active limits
// - limit stops set error bits 0,1
// - mode bit 8 enables slow-down function
// - decel mode: constant ignores, accel follows
// - start with slow-down active runs low
// - latched decel mode never reaccelerates
// - decel-stop: constant stops, accel may resume
// - latched decel-stop: constant pattern stops immediately
// - latched decel-stop keeps decelerating to stop
// - decel-stop start with slow-down completes motionless
// - slow-down stop sets bit 5, error event
// - latch clears at clean start or disable
// - env bits 6,4,5: polarity, stop, latch
// - latch in sub-status 15, input extension 14
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "alsi_cfg.svh"
module alsi_axis
    import alsi_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        positive_limit_in,
    input  wire logic        negative_limit_in,
    input  wire logic        slowdown_in,
    input  wire logic        limit_polarity_in,
    input  wire logic        start_req,
    input  wire logic        start_dir,
    input  wire logic [1:0]  start_pattern,
    input  wire logic        low_speed_reached,
    input  wire logic        motion_done,
    output logic             axis_running,
    output logic             axis_dir,
    output logic             high_speed_req,
    output logic             decel_stop_active,
    output logic             immediate_stop,
    output logic             start_refused,
    output logic             start_no_motion,
    output logic             error_event
);

    alsi_regs_t  r;           // registered state
    alsi_regs_t  next_r;      // next state
    logic [7:0]  flt_width;   // width for all three filters
    logic        pel_flt;     // filtered positive limit pin
    logic        mel_flt;     // filtered negative limit pin
    logic        sd_flt;      // filtered slow-down pin
    logic        pos_act;     // positive limit active
    logic        neg_act;     // negative limit active
    logic        sd_act;      // slow-down input active
    logic        sd_eff;      // slow-down as seen by motion logic
    logic        msde;        // slow-down function enabled
    logic        sdm;         // slow-down stops instead of slowing
    logic        sdlt;        // slow-down latch enabled
    logic        lim_hit;     // limit active in moving direction
    logic        apb_setup;   // setup phase of a transfer
    logic        wr_en;       // completing write
    logic        addr_hit;    // address maps to a register
    logic [31:0] rd_val;      // read word for paddr
    logic [2:0]  err_set;     // error causes raised this cycle
    logic [2:0]  err_clr;     // error bits cleared by software

    // filter width select
    always_comb begin
        flt_width = `ALSI_NOFLT_CYC;
        if (r.env[`ALSI_ENV1_FLTR]) begin
            case (r.env[`ALSI_ENV1_FTM_HI:`ALSI_ENV1_FTM_LO])
                2'h0:    flt_width = 8'(`ALSI_FT0_CYC);
                2'h1:    flt_width = 8'(`ALSI_FT1_CYC);
                2'h2:    flt_width = 8'(`ALSI_FT2_CYC);
                default: flt_width = 8'(`ALSI_FT3_CYC);
            endcase
        end
    end

    // one synchroniser and filter per switch input
    alsi_filter u_pel (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .pin_in    (positive_limit_in),
        .width_cyc (flt_width),
        .level     (pel_flt)
    );
    alsi_filter u_mel (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .pin_in    (negative_limit_in),
        .width_cyc (flt_width),
        .level     (mel_flt)
    );
    alsi_filter u_sd (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .pin_in    (slowdown_in),
        .width_cyc (flt_width),
        .level     (sd_flt)
    );

    // polarity after filtering, before stop logic
    assign pos_act = r.pol2 ? ~pel_flt : pel_flt;
    assign neg_act = r.pol2 ? ~mel_flt : mel_flt;
    assign sd_act  = r.env[`ALSI_ENV1_SDL] ? sd_flt : ~sd_flt;
    assign msde    = r.mode[`ALSI_MODE_MSDE];
    assign sdm     = r.env[`ALSI_ENV1_SDM];
    assign sdlt    = r.env[`ALSI_ENV1_SDLT];
    // latched mode reacts to the latch only
    assign sd_eff  = sdlt ? r.latch : sd_act;
    assign lim_hit = r.dir ? pos_act : neg_act;

    // apb decode
    assign apb_setup = psel & ~penable;
    assign wr_en     = psel & penable & r.pready & pwrite;

    // read mux with status words
    always_comb begin
        rd_val   = `ALSI_RST_WORD;
        addr_hit = 1'b1;
        case (paddr)
            `ALSI_OFS_ENV1: rd_val = r.env;
            `ALSI_OFS_ERR: begin
                rd_val[`ALSI_ERR_PL] = r.err[0];
                rd_val[`ALSI_ERR_ML] = r.err[1];
                rd_val[`ALSI_ERR_SD] = r.err[2];
            end
            `ALSI_OFS_MODE: rd_val = r.mode;
            `ALSI_OFS_SSTS: begin
                rd_val[`ALSI_SSTS_PL]    = pos_act;
                rd_val[`ALSI_SSTS_ML]    = neg_act;
                rd_val[`ALSI_SSTS_LATCH] = r.latch;
            end
            `ALSI_OFS_XSTS: rd_val[`ALSI_XSTS_SD] = sd_act;
            default:        addr_hit = 1'b0;
        endcase
    end

    // next state: registers, latch and axis motion
    always_comb begin
        next_r = r;
        err_set = 3'h0;
        err_clr = 3'h0;
        // polarity strap pin, two flops
        next_r.pol1 = limit_polarity_in;
        next_r.pol2 = r.pol1;
        // one-cycle pulses
        next_r.imm_stop  = 1'b0;
        next_r.refused   = 1'b0;
        next_r.no_motion = 1'b0;
        next_r.err_evt   = 1'b0;
        // apb: answer one cycle after setup
        next_r.pready  = apb_setup;
        next_r.pslverr = apb_setup & ~addr_hit;
        if (apb_setup) begin
            next_r.prdata = rd_val;
        end
        // register writes; error bits are write-one-to-clear
        if (wr_en) begin
            case (paddr)
                `ALSI_OFS_ENV1: next_r.env = pwdata;
                `ALSI_OFS_MODE: next_r.mode = pwdata;
                `ALSI_OFS_ERR: begin
                    err_clr = {pwdata[`ALSI_ERR_SD],
                               pwdata[`ALSI_ERR_ML],
                               pwdata[`ALSI_ERR_PL]};
                end
                default:        next_r.env = r.env;
            endcase
        end
        // slow-down latch: clears on disable or on clean start
        if (!sdlt) begin
            next_r.latch = 1'b0;
        end else if (start_req && r.st == ALSI_IDLE && !sd_act) begin
            next_r.latch = 1'b0;
        end else if (sd_act) begin
            next_r.latch = 1'b1;
        end
        // motion sequencing
        case (r.st)
            ALSI_IDLE: begin
                if (start_req) begin
                    if (start_dir ? pos_act : neg_act) begin
                        // start toward an active limit
                        next_r.refused = 1'b1;
                    end else if (msde && sdm && sd_act) begin
                        // ends at once with no motion
                        next_r.no_motion = 1'b1;
                    end else begin
                        next_r.st    = ALSI_RUN;
                        next_r.dir   = start_dir;
                        next_r.pat   = alsi_pat_t'(start_pattern);
                        next_r.cause = 3'h0;
                    end
                end
            end
            ALSI_RUN: begin
                if (lim_hit) begin
                    // abnormal stop on limit
                    if (r.env[`ALSI_ENV1_ELM]) begin
                        // decelerate past the limit
                        next_r.st    = ALSI_DSTOP;
                        next_r.cause = r.dir ? 3'h1 : 3'h2;
                    end else begin
                        next_r.st       = ALSI_IDLE;
                        next_r.imm_stop = 1'b1;
                        next_r.err_evt  = 1'b1;
                        err_set         = r.dir ? 3'h1 : 3'h2;
                    end
                end else if (motion_done) begin
                    next_r.st = ALSI_IDLE;
                end else if (msde && sdm && sd_eff) begin
                    if (r.pat != ALSI_PAT_ACCEL) begin
                        // constant pattern stops at once
                        next_r.st       = ALSI_IDLE;
                        next_r.imm_stop = 1'b1;
                        next_r.err_evt  = 1'b1;
                        err_set         = 3'h4;
                    end else begin
                        next_r.st    = ALSI_DSTOP;
                        next_r.cause = 3'h4;
                    end
                end
            end
            ALSI_DSTOP: begin
                if (lim_hit && r.cause == 3'h4) begin
                    // a limit overrides a slow-down cause
                    next_r.cause = r.dir ? 3'h1 : 3'h2;
                end else if (low_speed_reached || motion_done) begin
                    next_r.st      = ALSI_IDLE;
                    next_r.err_evt = 1'b1;
                    err_set        = r.cause;
                end else if (r.cause == 3'h4 && !sd_eff) begin
                    // unlatched input cleared, reaccelerate
                    next_r.st = ALSI_RUN;
                end
            end
            default: begin
                next_r.st = ALSI_IDLE;
            end
        endcase
        // a new cause beats a software clear in the same cycle
        next_r.err = (r.err & ~err_clr) | err_set;
        // registered motion outputs
        next_r.running = next_r.st != ALSI_IDLE;
        next_r.dstop   = next_r.st == ALSI_DSTOP;
        next_r.hs      = (next_r.st == ALSI_RUN) &&
                         ((next_r.pat == ALSI_PAT_HIGH) ||
                          (next_r.pat == ALSI_PAT_ACCEL && !(msde && sd_eff)));
    end

    // state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r       <= '0;
            r.st    <= ALSI_IDLE;
            r.pat   <= ALSI_PAT_LOW;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // outputs straight from flops
    assign prdata            = r.prdata;
    assign pready            = r.pready;
    assign pslverr           = r.pslverr;
    assign axis_running      = r.running;
    assign axis_dir          = r.dir;
    assign high_speed_req    = r.hs;
    assign decel_stop_active = r.dstop;
    assign immediate_stop    = r.imm_stop;
    assign start_refused     = r.refused;
    assign start_no_motion   = r.no_motion;
    assign error_event       = r.err_evt;

    // checks on the design's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sequence s_run_pos_limit;
        r.st == ALSI_RUN && r.dir && pos_act;
    endsequence

    property p_limit_imm;
        s_run_pos_limit ##0 !r.env[`ALSI_ENV1_ELM]
            |=> immediate_stop && !axis_running;
    endproperty
    a_limit_imm: assert property (p_limit_imm)
        else $error("limit did not stop axis at once");

    property p_limit_decel;
        s_run_pos_limit ##0 r.env[`ALSI_ENV1_ELM]
            |=> decel_stop_active && axis_running;
    endproperty
    a_limit_decel: assert property (p_limit_decel)
        else $error("limit did not start decel stop");

    property p_refuse;
        r.st == ALSI_IDLE && start_req && start_dir && pos_act
            |=> start_refused && !axis_running;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("start toward active limit accepted");

    property p_polarity;
        !r.pol2 && apb_setup && paddr == `ALSI_OFS_SSTS
            |=> prdata[`ALSI_SSTS_PL] == $past(pel_flt);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("limit polarity wrong");

    property p_err_pos;
        s_run_pos_limit ##0 !r.env[`ALSI_ENV1_ELM]
            |=> r.err[0] && error_event;
    endproperty
    a_err_pos: assert property (p_err_pos)
        else $error("positive limit cause not set");

    property p_no_sd;
        r.st == ALSI_RUN && r.pat == ALSI_PAT_ACCEL && !msde
            && !lim_hit && !motion_done |=> high_speed_req;
    endproperty
    a_no_sd: assert property (p_no_sd)
        else $error("speed dropped with slow-down off");

    property p_latch_hold;
        sdlt && r.latch && !(start_req && r.st == ALSI_IDLE)
            |=> r.latch;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("slow-down latch lost");

    property p_no_motion;
        r.st == ALSI_IDLE && start_req && msde && sdm && sd_act
            && !(start_dir ? pos_act : neg_act)
            |=> start_no_motion ##1 !axis_running;
    endproperty
    a_no_motion: assert property (p_no_motion)
        else $error("start ran with slow-down active");

    property p_sd_stop;
        r.st == ALSI_DSTOP && r.cause == 3'h4 && !lim_hit
            && low_speed_reached |=> r.err[2] && error_event;
    endproperty
    a_sd_stop: assert property (p_sd_stop)
        else $error("slow-down stop not reported");
endmodule

// ### verification/alsi_switches.sv
// model of the machine switches and of the axis speed ramp
// assumes the bench sets switch states; pins carry wire polarity
`timescale 1ns/1ps
module alsi_switches
    import alsi_pkg::*;
(
    input  wire logic pclk,
    input  wire logic pos_on,
    input  wire logic neg_on,
    input  wire logic sd_on,
    input  wire logic lim_pol,
    input  wire logic sd_high,
    input  wire logic slow,
    input  wire logic hs,
    output logic      positive_limit_in,
    output logic      negative_limit_in,
    output logic      slowdown_in,
    output logic      limit_polarity_in,
    output logic      low_speed_reached
);
    logic [4:0] ramp; // cycles spent below high speed
    // limit wiring: low select means active-high switches
    assign limit_polarity_in = lim_pol;
    assign positive_limit_in = pos_on ^ lim_pol;
    assign negative_limit_in = neg_on ^ lim_pol;
    // slow-down wiring follows the polarity bit of env one
    assign slowdown_in = sd_on ~^ sd_high;
    // ramp restarts while high speed is asked for
    always_ff @(posedge pclk) begin
        if (hs !== 1'b0) begin
            ramp <= 5'h00;
        end else if (ramp != 5'h1F) begin
            ramp <= ramp + 5'h01;
        end
    end
    // slow ramp takes 30 cycles, prompt one a single cycle
    assign low_speed_reached = ramp >= (slow ? 5'h1E : 5'h01);
endmodule

// ### verification/test_alsi_axis.sv
// self-checking bench for the axis limit and slow-down block
// assumes alsi_switches stands in for the machine switches
`timescale 1ns/1ps
`include "alsi_cfg.svh"
module test_alsi_axis
    import alsi_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic        e;
    } alsi_row_t;
    logic        pclk, presetn, psel, penable, pwrite, perr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, start_req, start_dir, motion_done;
    logic [1:0]  start_pattern;
    logic        axis_running, axis_dir, high_speed_req, decel_stop_active;
    logic        immediate_stop, start_refused, start_no_motion;
    logic        error_event, low_speed_reached;
    logic        pos_on, neg_on, sd_on, lim_pol, sd_high, slow;
    logic        pl_pin, nl_pin, sd_pin, lp_pin;
    logic [3:0]  seen; // sticky {stop, refused, no motion, error}
    int          miscompares, tests_run, cyc;
    // register reset values and one unmapped address
    alsi_row_t   rows [6] = '{
        '{`ALSI_OFS_ENV1, 32'h0, 1'b0}, '{`ALSI_OFS_ERR, 32'h0, 1'b0},
        '{`ALSI_OFS_MODE, 32'h0, 1'b0}, '{`ALSI_OFS_SSTS, 32'h0, 1'b0},
        '{`ALSI_OFS_XSTS, 32'h0, 1'b0}, '{8'h14, 32'h0, 1'b1}};

    alsi_axis i_alsi_axis (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .positive_limit_in(pl_pin),
        .negative_limit_in(nl_pin), .slowdown_in(sd_pin),
        .limit_polarity_in(lp_pin), .start_req(start_req),
        .start_dir(start_dir), .start_pattern(start_pattern),
        .low_speed_reached(low_speed_reached), .motion_done(motion_done),
        .axis_running(axis_running), .axis_dir(axis_dir),
        .high_speed_req(high_speed_req),
        .decel_stop_active(decel_stop_active),
        .immediate_stop(immediate_stop), .start_refused(start_refused),
        .start_no_motion(start_no_motion), .error_event(error_event));
    alsi_switches i_alsi_switches (.pclk(pclk), .pos_on(pos_on),
        .neg_on(neg_on), .sd_on(sd_on), .lim_pol(lim_pol),
        .sd_high(sd_high), .slow(slow), .hs(high_speed_req),
        .positive_limit_in(pl_pin), .negative_limit_in(nl_pin),
        .slowdown_in(sd_pin), .limit_polarity_in(lp_pin),
        .low_speed_reached(low_speed_reached));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // pulse catcher and hang guard
    always @(posedge pclk) begin
        seen <= seen | {immediate_stop, start_refused, start_no_motion,
                        error_event};
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) miscompares++;
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // set switch states, then let sync and filter settle when filter bit 26 is clear
    task automatic sw(input logic p, input logic n, input logic s);
        @(posedge pclk);
        pos_on <= p;
        neg_on <= n;
        sd_on <= s;
        tick(10);
    endtask
    task automatic start(input logic d, input logic [1:0] p);
        @(negedge pclk);
        seen = 4'h0;
        @(posedge pclk);
        start_req <= 1'b1;
        start_dir <= d;
        start_pattern <= p;
        @(posedge pclk);
        start_req <= 1'b0;
        tick(4);
    endtask
    task automatic finish_move();
        @(posedge pclk);
        motion_done <= 1'b1;
        @(posedge pclk);
        motion_done <= 1'b0;
        tick(2);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, start_req, start_dir} = 6'h0;
        {motion_done, pos_on, neg_on, sd_on, lim_pol, sd_high} = 6'h0;
        {paddr, pwdata, start_pattern, slow, seen} = 47'h0;
        tick(20);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            rdc(rows[i].a, rows[i].d);
            chk(perr, rows[i].e);
        end
        $display("done: reset values");
        sd_high <= 1'b1;
        apb(1'b1, `ALSI_OFS_ENV1, 32'h40);
        rdc(`ALSI_OFS_ENV1, 32'h40);
        apb(1'b1, `ALSI_OFS_MODE, 32'h100);
        rdc(`ALSI_OFS_MODE, 32'h100);
        sw(1'b1, 1'b0, 1'b0);
        rdc(`ALSI_OFS_SSTS, 32'h1000);
        sw(1'b1, 1'b1, 1'b0);
        lim_pol <= 1'b1;
        tick(10);
        rdc(`ALSI_OFS_SSTS, 32'h3000);
        start(1'b1, 2'h0);
        chk(seen, 4'b0100);
        start(1'b0, 2'h0);
        chk(seen, 4'b0100);
        $display("done: limit status and refusal");
        sw(1'b0, 1'b0, 1'b0);
        start(1'b1, 2'h0);
        chk({axis_running, axis_dir}, 2'b11);
        sw(1'b1, 1'b0, 1'b0);
        chk(seen, 4'b1001);
        chk(axis_running, 1'b0);
        rdc(`ALSI_OFS_ERR, 32'h1);
        apb(1'b1, `ALSI_OFS_ERR, 32'h1);
        rdc(`ALSI_OFS_ERR, 32'h0);
        $display("done: immediate limit stop");
        sw(1'b0, 1'b0, 1'b0);
        slow <= 1'b1;
        apb(1'b1, `ALSI_OFS_ENV1, 32'h48);
        start(1'b0, 2'h2);
        sw(1'b0, 1'b1, 1'b0);
        chk(decel_stop_active, 1'b1);
        chk(axis_running, 1'b1);
        chk(axis_dir, 1'b0);
        tick(40);
        chk(axis_running, 1'b0);
        rdc(`ALSI_OFS_ERR, 32'h2);
        apb(1'b1, `ALSI_OFS_ERR, 32'h2);
        $display("done: decel limit stop");
        sw(1'b0, 1'b0, 1'b0);
        apb(1'b1, `ALSI_OFS_ENV1, 32'h40);
        start(1'b1, 2'h2);
        chk(high_speed_req, 1'b1);
        sw(1'b0, 1'b0, 1'b1);
        chk(high_speed_req, 1'b0);
        rdc(`ALSI_OFS_XSTS, 32'h4000);
        sw(1'b0, 1'b0, 1'b0);
        chk(high_speed_req, 1'b1);
        finish_move();
        sw(1'b0, 1'b0, 1'b1);
        start(1'b1, 2'h2);
        chk(high_speed_req, 1'b0);
        sw(1'b0, 1'b0, 1'b0);
        chk(high_speed_req, 1'b1);
        finish_move();
        $display("done: decelerate mode");
        apb(1'b1, `ALSI_OFS_ENV1, 32'h60);
        @(posedge pclk);
        sd_on <= 1'b1;
        tick(2);
        sd_on <= 1'b0;
        tick(6);
        rdc(`ALSI_OFS_SSTS, 32'h8000);
        start(1'b1, 2'h2);
        sw(1'b0, 1'b0, 1'b1);
        sw(1'b0, 1'b0, 1'b0);
        chk(high_speed_req, 1'b0);
        rdc(`ALSI_OFS_SSTS, 32'h8000);
        apb(1'b1, `ALSI_OFS_ENV1, 32'h40);
        rdc(`ALSI_OFS_SSTS, 32'h0);
        finish_move();
        $display("done: latched decelerate");
        apb(1'b1, `ALSI_OFS_ENV1, 32'h50);
        start(1'b1, 2'h0);
        sw(1'b0, 1'b0, 1'b1);
        chk(seen, 4'b1001);
        rdc(`ALSI_OFS_ERR, 32'h20);
        apb(1'b1, `ALSI_OFS_ERR, 32'h20);
        start(1'b0, 2'h2);
        chk(seen[1], 1'b1);
        chk(axis_running, 1'b0);
        sw(1'b0, 1'b0, 1'b0);
        apb(1'b1, `ALSI_OFS_ENV1, 32'h70);
        start(1'b1, 2'h0);
        sw(1'b0, 1'b0, 1'b1);
        chk(seen, 4'b1001);
        sw(1'b0, 1'b0, 1'b0);
        start(1'b1, 2'h2);
        sw(1'b0, 1'b0, 1'b1);
        chk(decel_stop_active, 1'b1);
        sw(1'b0, 1'b0, 1'b0);
        chk({decel_stop_active, high_speed_req}, 2'b10);
        tick(30);
        chk(axis_running, 1'b0);
        $display("done: decelerate and stop");
        apb(1'b1, `ALSI_OFS_ENV1, 32'h0400_0040);
        sw(1'b0, 1'b0, 1'b1);
        tick(50);
        rdc(`ALSI_OFS_XSTS, 32'h0);
        tick(100);
        rdc(`ALSI_OFS_XSTS, 32'h4000);
        $display("done: noise filter");
        final_report();
    end
endmodule
